// [logic/rtw_defines.vh]
// Purpose: Shared constants for the clock chip two-wire slave port
// Assumes: System clock of 40 MHz, link lines sampled as plain inputs
// Notes:   Definitions only, no logic
`ifndef RTW_DEFINES_VH
`define RTW_DEFINES_VH

// ****************************************************************
// Address and widths
// ****************************************************************
`define RTW_SLAVE_ADDR   7'h51
`define RTW_PTR_RESET    8'h00
`define RTW_BIT_LAST     3'h7

// ****************************************************************
// Timing and register store depth
// ****************************************************************
`define RTW_CLK_PERIOD_NS 25
`define RTW_RAM_DEPTH     256

`endif

// [logic/rtw_sync.v]
// Purpose: Two-flop synchroniser for the two bus line inputs
// Assumes: Inputs asynchronous to clk
// Notes:   Resets to high, the released bus level
`timescale 1ns/1ps

module rtw_sync (
  // Clock and reset
  input  wire       clk,
  input  wire       resetn,
  // Raw and synchronised lines
  input  wire [1:0] line_in,
  output reg  [1:0] line_out
);

  reg [1:0] stage1;

  // Two stages; first stage feeds only the second
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1   <= 2'h3;
      line_out <= 2'h3;
    end else begin
      stage1   <= line_in;
      line_out <= stage1;
    end
  end

endmodule

// [logic/rtw_slave.v]
// Purpose: Two-wire slave port joining a master to the clock registers
// Assumes: Bus clock far slower than clk; lines pulled up outside
// Notes:   Register store lives outside; reached by pointer and data path
`timescale 1ns/1ps
`include "rtw_defines.vh"

module rtw_slave (
  // Clock and reset
  input  wire       clk,
  input  wire       resetn,
  // Bus lines
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  // Register data path
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata,
  output reg        reg_wr,
  output reg        reg_rd,
  input  wire [7:0] reg_rdata,
  // Status
  output reg        busy
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_RX   = 3'h2;
  localparam ST_TX   = 3'h3;
  localparam ST_ACK  = 3'h4;
  localparam ST_MACK = 3'h5;
  localparam ST_WAIT = 3'h6;

  reg  [2:0] state;
  reg  [2:0] ret_state;
  reg  [2:0] bit_cnt;
  reg  [7:0] shreg;
  reg        first_byte;
  reg        shreg_done;
  reg        scl_d;
  reg        sda_d;
  wire [1:0] lines;
  wire       scl;
  wire       sda;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_cond;
  wire       stop_cond;

  // ****************************************************************
  // Line sampling
  // ****************************************************************
  rtw_sync u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .line_in  ({scl_in, sda_in}),
    .line_out (lines)
  );

  assign scl = lines[1];
  assign sda = lines[0];

  // Previous synchronised levels for edge finding
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  assign scl_rise = scl & ~scl_d;
  assign scl_fall = ~scl & scl_d;
  assign start_cond = scl & scl_d & sda_d & ~sda;
  assign stop_cond  = scl & scl_d & ~sda_d & sda;

  // ****************************************************************
  // Protocol engine
  // ****************************************************************
  // Conditions are checked first, so a data change with the clock high
  // never lands in the shift register.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state      <= ST_IDLE;
      ret_state  <= ST_IDLE;
      bit_cnt    <= 3'h0;
      shreg      <= 8'h00;
      first_byte <= 1'b0;
      sda_out    <= 1'b0;
      sda_oe     <= 1'b0;
      reg_addr   <= `RTW_PTR_RESET;
      reg_wdata  <= 8'h00;
      reg_wr     <= 1'b0;
      reg_rd     <= 1'b0;
      busy       <= 1'b0;
    end else begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      // pointer steps once the stored byte has gone out
      if (reg_wr)
        reg_addr <= reg_addr + 8'h01;
      // output low only, enable shows pull-down
      sda_out <= 1'b0;
      if (stop_cond) begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
        busy   <= 1'b0;
      end else if (start_cond) begin
        state   <= ST_ADDR;
        bit_cnt <= 3'h0;
        sda_oe  <= 1'b0;
        busy    <= 1'b1;
      end else begin
        case (state)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              shreg   <= {shreg[6:0], sda};
              bit_cnt <= bit_cnt + 3'h1;
            end
            if (scl_fall && bit_cnt == 3'h0 && shreg_done) begin
              if (state == ST_ADDR) begin
                if (shreg[7:1] == `RTW_SLAVE_ADDR) begin
                  sda_oe     <= 1'b1;
                  first_byte <= 1'b1;
                  ret_state  <= shreg[0] ? ST_TX : ST_RX;
                  if (shreg[0])
                    reg_rd <= 1'b1;
                  state <= ST_ACK;
                end else begin
                  state <= ST_WAIT;
                end
              end else begin
                sda_oe    <= 1'b1;
                ret_state <= ST_RX;
                state     <= ST_ACK;
                if (first_byte) begin
                  reg_addr   <= shreg;
                  first_byte <= 1'b0;
                end else begin
                  reg_wdata <= shreg;
                  reg_wr    <= 1'b1;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (ret_state == ST_TX) begin
                shreg   <= {reg_rdata[6:0], 1'b0};
                sda_oe  <= ~reg_rdata[7];
                bit_cnt <= 3'h1;
              end else begin
                sda_oe  <= 1'b0;
                bit_cnt <= 3'h0;
              end
              state <= ret_state;
            end
          end
          ST_TX: begin
            // change data only on falling clock
            if (scl_fall) begin
              if (bit_cnt == 3'h0) begin
                sda_oe   <= 1'b0;
                reg_addr <= reg_addr + 8'h01;
                state    <= ST_MACK;
              end else begin
                sda_oe  <= ~shreg[7];
                shreg   <= {shreg[6:0], 1'b0};
                bit_cnt <= bit_cnt + 3'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              if (sda) begin
                state <= ST_WAIT;
              end else begin
                reg_rd <= 1'b1;
                ret_state <= ST_TX;
                state  <= ST_ACK;
              end
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Track that all eight bits of the current unit arrived
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shreg_done <= 1'b0;
    end else if (start_cond || stop_cond) begin
      shreg_done <= 1'b0;
    end else if (scl_rise && (state == ST_ADDR || state == ST_RX)) begin
      shreg_done <= (bit_cnt == `RTW_BIT_LAST);
    end else if (scl_fall) begin
      shreg_done <= 1'b0;
    end
  end

endmodule

// [tb/rtw_slave_assertions.sv]
// Purpose: Port checks for the two-wire slave port
// Assumes: Bus lines come straight from the bench wires
// Notes:   Bound to rtw_slave from the bench top
`timescale 1ns/1ps
module rtw_slave_assertions (
  // Clock and reset
  input wire       clk,
  input wire       resetn,
  // Bus lines
  input wire       scl_in,
  input wire       sda_in,
  input wire       sda_out,
  input wire       sda_oe,
  // Register path and status
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  pull_only_a: assert property (!sda_out)
    else $error("sda_out not low");
  oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda_oe moved with clock high");
  idle_free_a: assert property (!busy |-> !sda_oe)
    else $error("data pulled while idle");
  wr_once_a: assert property (reg_wr |=> !reg_wr)
    else $error("write pulse too long");
  wr_busy_a: assert property (reg_wr |-> busy)
    else $error("write outside transfer");
  wr_step_a: assert property (reg_wr |=> reg_addr == $past(reg_addr) + 8'h01)
    else $error("pointer did not step after write");
  rd_once_a: assert property (reg_rd |=> !reg_rd)
    else $error("read pulse too long");
  stop_idle_a: assert property (scl_in && $rose(sda_in) |-> ##[1:8] !busy)
    else $error("stop not seen");
  start_busy_a: assert property (scl_in && $fell(sda_in) |-> ##[1:8] busy)
    else $error("start not seen");
  ack_hold_a: assert property ($rose(sda_oe) |=> sda_oe[*4])
    else $error("data pull too short");
  cover property (reg_wr);
  cover property (reg_rd);
  cover property ($rose(sda_oe));
endmodule

// [tb/rtw_master_model.sv]
// Purpose: Behavioural bus master driving the slave port
// Assumes: Pull-up on the data line outside this model; clock driven directly
// Notes:   Clock low time can be stretched for slow masters
`timescale 1ns/1ps
module rtw_master_model (
  // Bus lines
  output logic scl,
  output logic sda_pull,
  input  wire  sda
);
  time low = 110;  // Long low leaves the slave time to let go
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task start;
    #25 sda_pull = 1'b0;
    #(low) scl = 1'b1;
    #100 sda_pull = 1'b1;
    #100 scl = 1'b0;
  endtask
  task stop;
    #25 sda_pull = 1'b1;
    #(low) scl = 1'b1;
    #100 sda_pull = 1'b0;
    #100;
  endtask
  task bit_io(input logic b, output logic r);
    #25 sda_pull = !b;
    #(low) scl = 1'b1;
    #40 r = sda;
    #25 scl = 1'b0;
  endtask
  task xfer(input logic [7:0] d, input logic ai,
            output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ai, ak);
  endtask
endmodule

// [tb/rtw_slave_tb_top.sv]
// Purpose: Self-checking bench for the two-wire slave port
// Assumes: Master model on the far side, pulled-up data line
// Notes:   Register store stand-in returns inverted pointer
`timescale 1ns/1ps
`include "rtw_defines.vh"
module rtw_slave_tb_top;
  logic        clk = 0;
  logic        resetn = 0;
  logic [7:0]  rdata = 8'h00;
  logic [7:0]  q;
  logic        a;
  logic [15:0] wq[$];
  int          miscompares = 0;
  int          comparisons = 0;
  wire         scl, pull, sda_oe, sda_out, reg_wr, reg_rd, busy;
  wire [7:0]   reg_addr, reg_wdata;
  wire         sda = !(pull || (sda_oe && !sda_out));  // Wired-AND
  rtw_slave i_dut (.clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .busy(busy));
  rtw_master_model m (.scl(scl), .sda_pull(pull), .sda(sda));
  always #12.5 clk = ~clk;
  // Latch on request, so a later pointer move cannot disturb the byte
  always @(posedge clk) begin
    if (reg_rd) rdata <= ~reg_addr;
    if (reg_wr) wq.push_back({reg_addr, reg_wdata});
  end
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task send(input logic [7:0] d, input logic ea);
    m.xfer(d, 1'b1, q, a);
    chk("ack", {7'h00, ea}, {7'h00, a});
  endtask
  task t_write;
    m.start;
    send({`RTW_SLAVE_ADDR, 1'b0}, 1'b0);
    // pointers used here stay clear of the test addresses
    send(8'h10, 1'b0);
    send(8'h3C, 1'b0);
    send(8'hC3, 1'b0);
    chk("busy", 8'h01, {7'h00, busy});
    m.stop;
    repeat (8) @(posedge clk);
    #2;
    chk("busy", 8'h00, {7'h00, busy});
    chk("writes", 8'h02, 8'(wq.size()));
    chk("addr", 8'h10, wq[0][15:8]);
    chk("wdata", 8'h3C, wq[0][7:0]);
    chk("wdata", 8'hC3, wq[1][7:0]);
    chk("addr", 8'h11, wq[1][15:8]);
  endtask
  task t_read(input time lw);
    m.low = lw;
    m.start;
    send({`RTW_SLAVE_ADDR, 1'b0}, 1'b0);
    send(8'h80, 1'b0);
    m.start;
    send({`RTW_SLAVE_ADDR, 1'b1}, 1'b0);
    m.xfer(8'hFF, 1'b0, q, a);
    chk("rdata", 8'h7F, q);
    m.xfer(8'hFF, 1'b1, q, a);
    chk("rdata", 8'h7E, q);
    #150 chk("sda", 8'h01, {7'h00, sda});
    m.stop;
    m.low = 110;
  endtask
  task t_foreign;
    wq.delete();
    m.start;
    send(8'hA0, 1'b1);
    send(8'h55, 1'b1);
    m.start;
    send({`RTW_SLAVE_ADDR, 1'b0}, 1'b0);
    m.stop;
    chk("writes", 8'h00, 8'(wq.size()));
  endtask
  task wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Main sequence after ten reset cycles
  initial begin
    repeat (10) @(posedge clk);
    #2 resetn = 1'b1;
    repeat (4) @(posedge clk);
    #2;
    t_write;
    t_read(110);
    t_read(900);
    t_foreign;
    wrap_up;
  end
  // Watchdog well beyond the slow read
  initial begin
    #1000000;
    miscompares++;
    wrap_up;
  end
endmodule
bind rtw_slave rtw_slave_assertions u_chk (.clk(clk), .resetn(resetn),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy));
